// file: src/uspc_pkg.sv
// Behaviour
// - event port a is high while any flag chosen by mask bits 7:0 is high
// - event port b is high while any flag chosen by mask bits 15:8 is high
// - event port c is high while any flag chosen by mask bits 23:16 is high
// - event port d is high while any flag chosen by mask bits 31:24 is high; all masks reset to zero
// - frame counter is 11 bits, writable, high part 10:8, low part 7:0
// - last packet identifier is captured on each packet, read only, reset zero
// - endpoint register low nibble holds the endpoint of the last token
// - endpoint register bit 4 shows whether the endpoint field is valid
// - marked endpoints appear on the receive port with 0x10 ORed in
// - phy control bit 18 switches off pulldowns on both phy data ports
// - auto-resume by se0 sets phy control bit 13; writing zero clears it
// - auto-resume by k state sets phy control bit 12; writing zero clears it
// - line state changes propagate after two to the power bits 11:8 clocks
// - bit 7 lets the suspend controller resume; else software polls line state
// - phy config pins follow phy control bits 6:4, reset zero
// - the flag vector has seven bits; bit 6 marks a good decoded token
// - a held flag keeps its value until software writes one to it
package uspc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FLAG_W = 7;
  localparam int unsigned SOF_W = 11;
  localparam int unsigned EP_W = 4;
  localparam int unsigned PID_W = 4;
  localparam int unsigned FILT_W = 4;
  localparam int unsigned FILT_CNT_W = 16;
  localparam int unsigned IRQ_W = 3;
  localparam logic [ADDR_W-1:0] OFF_PORT_MASK = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_FRAME = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_PID = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_EP = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_EP_MARK = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_OTG_MASK = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_PWR_SIG = 8'h3c;
  localparam logic [ADDR_W-1:0] OFF_PHY_CTRL = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_LINE_STAT = 8'h44;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h48;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h4c;
  localparam int unsigned EP_VALID_BIT = 4;
  localparam logic [4:0] EP_MARK_OR = 5'h10;
  localparam int unsigned EP_MARK_W = 16;
  localparam int unsigned PORT_MASK_W = 8;
  localparam int unsigned PWR_SIG_W = 9;
  localparam int unsigned PHY_PD_DIS_BIT = 18;
  localparam int unsigned PHY_RES_SE0_BIT = 13;
  localparam int unsigned PHY_RES_K_BIT = 12;
  localparam int unsigned PHY_FILT_LO = 8;
  localparam int unsigned PHY_SUSP_BIT = 7;
  localparam int unsigned PHY_CONF_LO = 4;
  localparam int unsigned PHY_CONF_W = 3;
  localparam logic [DATA_W-1:0] PHY_RW_MASK = 32'h0004_3ff0;
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_K = 2'h2;
  localparam int unsigned IRQ_TOKEN = 0;
  localparam int unsigned IRQ_SOF = 1;
  localparam int unsigned IRQ_RESUME = 2;
  localparam int unsigned TOKEN_FLAG = 6;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } uspc_bus_s;

  typedef struct packed {
    logic pid_vld;
    logic [PID_W-1:0] pid;
    logic tok_vld;
    logic [EP_W-1:0] ep;
    logic ep_inval;
  } uspc_pkt_s;
endpackage : uspc_pkg

// file: src/uspc_top.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module uspc_top
  import uspc_pkg::*;
(
  input wire logic i_ref_clk, // 200 MHz clock
  input wire logic i_rst, // async reset, high
  input wire uspc_bus_s i_bus, // register request
  output logic [DATA_W-1:0] o_rdata, // read data, cycle after strobe
  input wire logic [FLAG_W-1:0] i_flag_src, // raw interface flag signals
  input wire logic [FLAG_W-1:0] i_flag_hold_select, // 1 = flag is held
  input wire logic i_flag_clr_wr, // write-one-to-clear strobe for flags
  input wire logic [FLAG_W-1:0] i_flag_clr_data, // ones clear held flags
  input wire uspc_pkt_s i_pkt, // packet and token capture
  input wire logic i_sof, // start-of-frame pulse
  input wire logic i_suspend, // link is suspended
  input wire logic [1:0] i_linestate, // phy line state pins
  output logic [FLAG_W-1:0] o_flags, // interface flag vector
  output logic o_event_port_a, // event port a
  output logic o_event_port_b, // event port b
  output logic o_event_port_c, // event port c
  output logic o_event_port_d, // event port d
  output logic [4:0] o_rx_ep, // endpoint on receive port
  output logic o_rx_ep_vld, // receive port endpoint strobe
  output logic o_phy_data_port_a_pd, // pulldown enable, data port a
  output logic o_phy_data_port_b_pd, // pulldown enable, data port b
  output logic [PHY_CONF_W-1:0] o_phy_config_pins, // phy config pins
  output logic [1:0] o_linestate_filt, // filtered line state
  output logic o_resume, // resume pulse to suspend logic
  output logic o_irq // level interrupt
);

  function automatic logic [FILT_CNT_W-1:0] pow2m1(input logic [FILT_W-1:0] n);
    logic [FILT_CNT_W:0] one;
    one = {{FILT_CNT_W{1'b0}}, 1'b1};
    pow2m1 = FILT_CNT_W'((one << n) - 1'b1);
  endfunction : pow2m1

  function automatic logic port_hit(input logic [PORT_MASK_W-1:0] m, input logic [FLAG_W-1:0] f);
    port_hit = |(m[FLAG_W-1:0] & f);
  endfunction : port_hit

  logic [DATA_W-1:0] port_mask_q;
  logic [SOF_W-1:0] sof_q;
  logic [PID_W-1:0] pid_q;
  logic [EP_W-1:0] ep_q;
  logic ep_vld_q;
  logic [EP_MARK_W-1:0] ep_mark_q;
  logic [DATA_W-1:0] otg_mask_q;
  logic [PWR_SIG_W-1:0] pwr_sig_q;
  logic [DATA_W-1:0] phy_ctrl_q;
  logic [DATA_W-1:0] phy_ctrl_d;
  logic [FLAG_W-1:0] flag_q;
  logic [FLAG_W-1:0] flag_d;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [1:0] ls_meta_q;
  logic [1:0] ls_sync_q;
  logic [1:0] ls_cand_q;
  logic [FILT_CNT_W-1:0] ls_cnt_q;
  logic [1:0] ls_filt_q;
  logic [1:0] ls_prev_q;
  logic [DATA_W-1:0] rdata_q;
  logic [3:0] port_q;
  logic [4:0] rx_ep_q;
  logic rx_ep_vld_q;
  logic resume_q;
  logic irq_q;
  logic pd_q;

  // register decode
  wire wr_port_mask = i_bus.wr && (i_bus.addr == OFF_PORT_MASK);
  wire wr_frame = i_bus.wr && (i_bus.addr == OFF_FRAME);
  wire wr_ep_mark = i_bus.wr && (i_bus.addr == OFF_EP_MARK);
  wire wr_otg_mask = i_bus.wr && (i_bus.addr == OFF_OTG_MASK);
  wire wr_pwr_sig = i_bus.wr && (i_bus.addr == OFF_PWR_SIG);
  wire wr_phy_ctrl = i_bus.wr && (i_bus.addr == OFF_PHY_CTRL);
  wire wr_irq_stat = i_bus.wr && (i_bus.addr == OFF_IRQ_STAT);
  wire wr_irq_mask = i_bus.wr && (i_bus.addr == OFF_IRQ_MASK);

  // filter limit and line state change detection
  wire [FILT_W-1:0] filt_log2 = phy_ctrl_q[PHY_FILT_LO +: FILT_W];
  wire [FILT_CNT_W-1:0] filt_lim = pow2m1(filt_log2);
  wire ls_stable = (ls_sync_q == ls_cand_q);
  // >= so a limit lowered mid-count does not run the counter round
  wire ls_done = ls_stable && (ls_cnt_q >= filt_lim);
  wire ls_change = (ls_filt_q != ls_prev_q);

  // auto-resume only while the suspend controller owns resume
  wire auto_en = phy_ctrl_q[PHY_SUSP_BIT] && i_suspend;
  wire res_se0 = auto_en && ls_change && (ls_filt_q == LS_SE0);
  wire res_k = auto_en && ls_change && (ls_filt_q == LS_K);

  // held flags keep value, set beats clear
  always_comb begin
    for (int i = 0; i < FLAG_W; i++) begin
      if (i_flag_hold_select[i]) begin
        flag_d[i] = i_flag_src[i] | (flag_q[i] & ~(i_flag_clr_wr & i_flag_clr_data[i]));
      end else begin
        flag_d[i] = i_flag_src[i];
      end
    end
  end

  // phy control: writable bits, resume causes set beats a zero write
  always_comb begin
    phy_ctrl_d = phy_ctrl_q;
    if (wr_phy_ctrl) begin
      phy_ctrl_d = i_bus.wdata & PHY_RW_MASK;
      phy_ctrl_d[PHY_RES_SE0_BIT] = phy_ctrl_q[PHY_RES_SE0_BIT]
        & i_bus.wdata[PHY_RES_SE0_BIT];
      phy_ctrl_d[PHY_RES_K_BIT] = phy_ctrl_q[PHY_RES_K_BIT]
        & i_bus.wdata[PHY_RES_K_BIT];
    end
    if (res_se0) begin
      phy_ctrl_d[PHY_RES_SE0_BIT] = 1'b1;
    end
    if (res_k) begin
      phy_ctrl_d[PHY_RES_K_BIT] = 1'b1;
    end
  end

  wire [IRQ_W-1:0] irq_evt = {res_se0 | res_k, i_sof, i_pkt.tok_vld};
  wire [IRQ_W-1:0] irq_w1c = wr_irq_stat ? i_bus.wdata[IRQ_W-1:0] : '0;
  assign irq_stat_d = irq_evt | (irq_stat_q & ~irq_w1c);

  // read mux
  wire [DATA_W-1:0] rd_mux =
    (i_bus.addr == OFF_PORT_MASK) ? port_mask_q :
    (i_bus.addr == OFF_FRAME) ? DATA_W'(sof_q) :
    (i_bus.addr == OFF_PID) ? DATA_W'(pid_q) :
    (i_bus.addr == OFF_EP) ? DATA_W'({ep_vld_q, ep_q}) :
    (i_bus.addr == OFF_EP_MARK) ? DATA_W'(ep_mark_q) :
    (i_bus.addr == OFF_OTG_MASK) ? otg_mask_q :
    (i_bus.addr == OFF_PWR_SIG) ? DATA_W'(pwr_sig_q) :
    (i_bus.addr == OFF_PHY_CTRL) ? phy_ctrl_q :
    (i_bus.addr == OFF_LINE_STAT) ? DATA_W'(ls_filt_q) :
    (i_bus.addr == OFF_IRQ_STAT) ? DATA_W'(irq_stat_q) :
    (i_bus.addr == OFF_IRQ_MASK) ? DATA_W'(irq_mask_q) : '0;

  wire [3:0] port_d = {port_hit(port_mask_q[3*PORT_MASK_W +: PORT_MASK_W], flag_q),
                       port_hit(port_mask_q[2*PORT_MASK_W +: PORT_MASK_W], flag_q),
                       port_hit(port_mask_q[PORT_MASK_W +: PORT_MASK_W], flag_q),
                       port_hit(port_mask_q[0 +: PORT_MASK_W], flag_q)};
  wire [4:0] rx_ep_d = {1'b0, i_pkt.ep} | (ep_mark_q[i_pkt.ep] ? EP_MARK_OR : '0);

  // software registers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      port_mask_q <= '0;
      ep_mark_q <= '0;
      otg_mask_q <= '0;
      pwr_sig_q <= '0;
      irq_mask_q <= '0;
    end else begin
      if (wr_port_mask) port_mask_q <= i_bus.wdata;
      if (wr_ep_mark) ep_mark_q <= i_bus.wdata[EP_MARK_W-1:0];
      if (wr_otg_mask) otg_mask_q <= i_bus.wdata;
      if (wr_pwr_sig) pwr_sig_q <= i_bus.wdata[PWR_SIG_W-1:0];
      if (wr_irq_mask) irq_mask_q <= i_bus.wdata[IRQ_W-1:0];
    end
  end

  // frame counter: write wins over a start-of-frame tick
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sof_q <= '0;
    end else if (wr_frame) begin
      sof_q <= i_bus.wdata[SOF_W-1:0];
    end else if (i_sof) begin
      sof_q <= sof_q + 1'b1;
    end
  end

  // packet and token capture
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pid_q <= '0;
      ep_q <= '0;
      ep_vld_q <= 1'b0;
    end else begin
      if (i_pkt.pid_vld) pid_q <= i_pkt.pid;
      if (i_pkt.tok_vld) begin
        ep_q <= i_pkt.ep;
        ep_vld_q <= 1'b1;
      end else if (i_pkt.ep_inval) begin
        ep_vld_q <= 1'b0;
      end
    end
  end

  // flags, ports and receive endpoint
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_q <= '0;
      port_q <= '0;
      rx_ep_q <= '0;
      rx_ep_vld_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      port_q <= port_d;
      rx_ep_q <= rx_ep_d;
      rx_ep_vld_q <= i_pkt.tok_vld;
    end
  end

  // line state synchroniser and filter
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ls_meta_q <= '0;
      ls_sync_q <= '0;
      ls_cand_q <= '0;
      ls_cnt_q <= '0;
      ls_filt_q <= '0;
      ls_prev_q <= '0;
    end else begin
      ls_meta_q <= i_linestate;
      ls_sync_q <= ls_meta_q;
      ls_prev_q <= ls_filt_q;
      if (!ls_stable) begin
        ls_cand_q <= ls_sync_q;
        ls_cnt_q <= '0;
      end else if (ls_done) begin
        ls_filt_q <= ls_cand_q;
      end else begin
        ls_cnt_q <= ls_cnt_q + 1'b1;
      end
    end
  end

  // phy control, interrupts, read data
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      phy_ctrl_q <= '0;
      irq_stat_q <= '0;
      irq_q <= 1'b0;
      resume_q <= 1'b0;
      rdata_q <= '0;
      pd_q <= 1'b1; // pulldowns on out of reset
    end else begin
      phy_ctrl_q <= phy_ctrl_d;
      pd_q <= ~phy_ctrl_d[PHY_PD_DIS_BIT];
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_q & irq_mask_q);
      resume_q <= res_se0 | res_k;
      rdata_q <= i_bus.rd ? rd_mux : '0;
    end
  end

  assign o_rdata = rdata_q;
  assign o_flags = flag_q;
  assign o_event_port_a = port_q[0];
  assign o_event_port_b = port_q[1];
  assign o_event_port_c = port_q[2];
  assign o_event_port_d = port_q[3];
  assign o_rx_ep = rx_ep_q;
  assign o_rx_ep_vld = rx_ep_vld_q;
  assign o_phy_data_port_a_pd = pd_q;
  assign o_phy_data_port_b_pd = pd_q;
  assign o_phy_config_pins = phy_ctrl_q[PHY_CONF_LO +: PHY_CONF_W];
  assign o_linestate_filt = ls_filt_q;
  assign o_resume = resume_q;
  assign o_irq = irq_q;

  // checks
  property p_port_a;
    @(posedge i_ref_clk) disable iff (i_rst)
    port_hit(port_mask_q[0 +: PORT_MASK_W], flag_q) |=> o_event_port_a;
  endproperty
  a_port_a: assert property (p_port_a) else $error("port a missed");

  property p_port_b;
    @(posedge i_ref_clk) disable iff (i_rst)
    o_event_port_b |-> $past(port_hit(port_mask_q[PORT_MASK_W +: PORT_MASK_W], flag_q));
  endproperty
  a_port_b: assert property (p_port_b) else $error("port b spurious");

  property p_port_c;
    @(posedge i_ref_clk) disable iff (i_rst)
    (port_mask_q[2*PORT_MASK_W +: PORT_MASK_W] == '0) [*2] |-> !o_event_port_c;
  endproperty
  a_port_c: assert property (p_port_c) else $error("port c high unmasked");

  property p_port_d;
    @(posedge i_ref_clk) disable iff (i_rst)
    o_event_port_d == $past(port_hit(port_mask_q[3*PORT_MASK_W +: PORT_MASK_W], flag_q));
  endproperty
  a_port_d: assert property (p_port_d) else $error("port d wrong");

  property p_sof_inc;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_sof && !wr_frame) |=> sof_q == SOF_W'($past(sof_q) + 1'b1);
  endproperty
  a_sof_inc: assert property (p_sof_inc) else $error("frame count wrong");

  property p_pid;
    @(posedge i_ref_clk) disable iff (i_rst)
    i_pkt.pid_vld |=> pid_q == $past(i_pkt.pid);
  endproperty
  a_pid: assert property (p_pid) else $error("pid not captured");

  property p_ep;
    @(posedge i_ref_clk) disable iff (i_rst)
    i_pkt.tok_vld |=> (ep_q == $past(i_pkt.ep)) && ep_vld_q;
  endproperty
  a_ep: assert property (p_ep) else $error("endpoint not captured");

  property p_mark;
    @(posedge i_ref_clk) disable iff (i_rst)
    i_pkt.tok_vld && ep_mark_q[i_pkt.ep] |=> o_rx_ep_vld && o_rx_ep[4];
  endproperty
  a_mark: assert property (p_mark) else $error("mark bit missing");

  property p_pd;
    @(posedge i_ref_clk) disable iff (i_rst)
    wr_phy_ctrl && i_bus.wdata[PHY_PD_DIS_BIT] |=> !o_phy_data_port_a_pd;
  endproperty
  a_pd: assert property (p_pd) else $error("pulldown still on");

  property p_res_se0;
    @(posedge i_ref_clk) disable iff (i_rst)
    res_se0 |=> phy_ctrl_q[PHY_RES_SE0_BIT] && o_resume;
  endproperty
  a_res_se0: assert property (p_res_se0) else $error("se0 cause lost");

  property p_res_k;
    @(posedge i_ref_clk) disable iff (i_rst)
    res_k |=> phy_ctrl_q[PHY_RES_K_BIT] && o_resume;
  endproperty
  a_res_k: assert property (p_res_k) else $error("k cause lost");

  property p_filt;
    @(posedge i_ref_clk) disable iff (i_rst)
    $changed(ls_filt_q) |-> $past(ls_cnt_q >= filt_lim);
  endproperty
  a_filt: assert property (p_filt) else $error("filter early");

  property p_no_auto;
    @(posedge i_ref_clk) disable iff (i_rst)
    !phy_ctrl_q[PHY_SUSP_BIT] |=> !o_resume;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("resume when off");

  property p_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
    flag_q[TOKEN_FLAG] && i_flag_hold_select[TOKEN_FLAG] && !i_flag_clr_wr
      |=> flag_q[TOKEN_FLAG];
  endproperty
  a_hold: assert property (p_hold) else $error("held flag dropped");

  c_port_a: cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(o_event_port_a));
  c_resume: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_resume);
  c_mark: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_rx_ep_vld && o_rx_ep[4]);
  c_irq: cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(o_irq));

endmodule : uspc_top
`default_nettype wire

// file: tb/uspc_phy_model.sv
`timescale 1ns/10ps
`default_nettype none
module uspc_phy_model
  import uspc_pkg::*;
(
  input wire logic i_ref_clk, // bench clock
  output logic [1:0] o_linestate, // line state pins
  output uspc_pkt_s o_pkt // receive capture strobes
);
  initial begin
    o_linestate = 2'h1;
    o_pkt = '0;
  end
  // line level holds until changed
  task automatic drive_line(input logic [1:0] ls);
    @(posedge i_ref_clk);
    o_linestate <= ls;
  endtask : drive_line
  // fields no longer valid show inverted junk
  task automatic send_token(input logic [3:0] pid, input logic [3:0] ep);
    @(posedge i_ref_clk);
    o_pkt <= {1'b1, pid, 1'b1, ep, 1'b0};
    @(posedge i_ref_clk);
    o_pkt <= {1'b0, ~pid, 1'b0, ~ep, 1'b0};
  endtask : send_token
  task automatic send_inval();
    @(posedge i_ref_clk);
    o_pkt.ep_inval <= 1'b1;
    @(posedge i_ref_clk);
    o_pkt.ep_inval <= 1'b0;
  endtask : send_inval
endmodule : uspc_phy_model
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import uspc_pkg::*;
  logic i_ref_clk;
  logic i_rst;
  uspc_bus_s bus;
  uspc_pkt_s pkt;
  logic [DATA_W-1:0] rdata;
  logic [FLAG_W-1:0] flag_src, hold_sel, clr_data, flags, s;
  logic clr_wr, sof, suspend, rx_ep_vld, pd_a, pd_b, resume, irq;
  logic [1:0] linestate, ls_filt;
  wire [3:0] ports;
  logic [3:0] e;
  logic [4:0] rx_ep;
  logic [PHY_CONF_W-1:0] conf;
  logic [15:0] lfsr_q;
  logic [31:0] d, m, ctrl;
  logic [31:0] wmask[int];
  int n_fail, total_checks, cnt;
  int lsv[3] = '{0, 2, 0};
  int bitv[3] = '{32'h2000, 32'h1000, 0};

  uspc_top u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata),
    .i_flag_src(flag_src), .i_flag_hold_select(hold_sel), .i_flag_clr_wr(clr_wr),
    .i_flag_clr_data(clr_data), .i_pkt(pkt), .i_sof(sof), .i_suspend(suspend),
    .i_linestate(linestate), .o_flags(flags), .o_event_port_a(ports[0]),
    .o_event_port_b(ports[1]), .o_event_port_c(ports[2]), .o_event_port_d(ports[3]),
    .o_rx_ep(rx_ep), .o_rx_ep_vld(rx_ep_vld), .o_phy_data_port_a_pd(pd_a),
    .o_phy_data_port_b_pd(pd_b), .o_phy_config_pins(conf), .o_linestate_filt(ls_filt),
    .o_resume(resume), .o_irq(irq));
  uspc_phy_model u_phy (.i_ref_clk(i_ref_clk), .o_linestate(linestate), .o_pkt(pkt));

  initial i_ref_clk = 1'b0;
  always #2.5 i_ref_clk = ~i_ref_clk;

  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return {lfsr_q, lfsr_q ^ 16'h5a5a};
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge i_ref_clk);
    bus <= {a, dat, 2'b10};
    @(posedge i_ref_clk);
    bus <= '0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    bus <= {a, 32'h0, 2'b01};
    @(posedge i_ref_clk);
    bus <= '0;
    #1 chk(rdata, exp);
  endtask : rd_chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    lfsr_q = 16'd56100;
    bus = '0;
    flag_src = '0;
    hold_sel = '0;
    clr_data = '0;
    clr_wr = 1'b0;
    sof = 1'b0;
    suspend = 1'b0;
    i_rst = 1'b1;
    wmask[8'h24] = 32'hffffffff;
    wmask[8'h28] = 32'h7ff;
    wmask[8'h2c] = 32'h0;
    wmask[8'h30] = 32'h0;
    wmask[8'h34] = 32'hffff;
    wmask[8'h38] = 32'hffffffff;
    wmask[8'h3c] = 32'h1ff;
    wmask[8'h40] = PHY_RW_MASK & ~32'h3000;
    wmask[8'h4c] = 32'h7;
    wmask[8'h50] = 32'h0;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1 chk({pd_a, pd_b, conf, ports}, {2'b11, 3'h0, 4'h0});
    for (int a = 'h24; a <= 'h40; a += 4) rd_chk(8'(a), 32'h0);
    $display("test reset values done");
    repeat (3) begin
      foreach (wmask[a]) begin
        d = rnd();
        wr(8'(a), d);
        rd_chk(8'(a), d & wmask[a]);
        if (a == 'h40) chk({pd_a, pd_b, conf}, {~d[18], ~d[18], d[6:4]});
      end
    end
    $display("test register access done");
    for (int i = 0; i < 24; i++) begin
      m = rnd() & 32'h7f7f7f7f;
      s = FLAG_W'(rnd());
      wr(8'h24, m);
      flag_src <= s;
      repeat (2) @(posedge i_ref_clk);
      #1;
      for (int k = 0; k < 4; k++) e[k] = |(s & m[8*k +: 7]);
      chk(32'(ports), 32'(e));
      chk(32'(flags), 32'(s));
    end
    $display("test event ports done");
    wr(8'h24, 32'h40);
    hold_sel <= 7'h40;
    flag_src <= 7'h40;
    @(posedge i_ref_clk);
    flag_src <= 7'h0;
    repeat (3) @(posedge i_ref_clk);
    #1 chk(32'({flags, ports[0]}), 32'h81);
    @(posedge i_ref_clk);
    clr_wr <= 1'b1;
    clr_data <= 7'h40;
    @(posedge i_ref_clk);
    clr_wr <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1 chk(32'({flags, ports[0]}), 32'h0);
    $display("test held flags done");
    wr(8'h28, 32'h7fe);
    @(posedge i_ref_clk);
    sof <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    sof <= 1'b0;
    rd_chk(8'h28, 32'h0);
    $display("test frame counter done");
    wr(8'h4c, 32'h0);
    wr(8'h48, 32'h7);
    wr(8'h34, 32'h0020);
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? 32'h5 : 32'h3;
      u_phy.send_token(4'(d + 5), 4'(d));
      #1 chk({rx_ep_vld, rx_ep}, {1'b1, (d == 5) ? 5'h10 : 5'h0} | d);
      rd_chk(8'h2c, d + 5);
      rd_chk(8'h30, 32'h10 | d);
    end
    u_phy.send_inval();
    rd_chk(8'h30, 32'h3);
    rd_chk(8'h48, 32'h1);
    chk(32'(irq), 32'h0);
    wr(8'h4c, 32'h1);
    repeat (2) @(posedge i_ref_clk);
    #1 chk(32'(irq), 32'h1);
    wr(8'h48, 32'h1);
    repeat (2) @(posedge i_ref_clk);
    #1 chk(32'(irq), 32'h0);
    $display("test packet capture done");
    wr(8'h4c, 32'h4);
    suspend <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      ctrl = (i == 2) ? 32'h250 : 32'h2d0;
      wr(8'h40, ctrl);
      u_phy.drive_line(2'(lsv[i]));
      cnt = 0;
      while (resume !== 1'b1 && cnt < 40) begin
        @(posedge i_ref_clk);
        #1 cnt++;
      end
      chk(32'(cnt >= 4 && cnt <= 12), 32'(bitv[i] != 0));
      repeat (2) @(posedge i_ref_clk);
      #1 chk(32'({ls_filt, irq}), 32'({2'(lsv[i]), bitv[i] != 0}));
      rd_chk(8'h44, lsv[i]);
      rd_chk(8'h40, ctrl | bitv[i]);
      wr(8'h40, ctrl);
      rd_chk(8'h40, ctrl);
      wr(8'h48, 32'h7);
      u_phy.drive_line(2'h1);
      repeat (20) @(posedge i_ref_clk);
    end
    $display("test auto resume done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
